// [src/lcsf_fifo.sv]
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two, at least two.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/1ps
module lcsf_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic rst,
    lcsf_stream_if.fifo port
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    // ============================================================
    // Parameter check.
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least two.");
    end
    // ============================================================
    // State.
    typedef struct packed {
        logic [D-1:0][W-1:0] mem; // Storage words.
        logic [AW-1:0] wp;        // Write pointer.
        logic [AW-1:0] rp;        // Read pointer.
        logic [CW-1:0] cnt;       // Words held.
    } lcsf_fifo_state_type;
    lcsf_fifo_state_type q;
    lcsf_fifo_state_type d;
    logic push;
    logic pop;
    // Handshakes: full refuses a push, empty refuses a pop.
    assign port.push_ready = (q.cnt != CW'(D));
    assign port.pop_valid = (q.cnt != '0);
    assign port.pop_data = q.mem[q.rp];
    assign push = port.push_valid && port.push_ready;
    assign pop = port.pop_ready && port.pop_valid;
    // Next state: store, advance pointers, track occupancy.
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = port.push_data;
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end
    // Register the state; reset empties the FIFO.
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// [src/lcsf_pkg.sv]
// Purpose: Shared constants for the link configuration block.
// Assumes: Register offsets are word indices; byte address is index * 4.
// Notes: Symbols are five bits; a token is two symbols.
package lcsf_pkg;
    // ============================================================
    // Sizes.
    localparam int NLINK = 8;                 // Number of links.
    localparam int LINK_W = 3;                // Width of a link number.
    localparam int GAP_W = 11;                // Width of a gap field.
    localparam int CNT_W = 12;                // Width of a gap counter.
    localparam int SYM_W = 5;                 // Width of a symbol.
    localparam int CHAN_W = 5;                // Width of a channel end.
    localparam int FIFO_DEPTH = 4;            // Forward FIFO depth.
    localparam int FWD_W = LINK_W + 1 + CHAN_W + 8; // FIFO word.
    // ============================================================
    // Register word indices.
    localparam logic [7:0] IDX_CFG = 8'h80;   // Link configuration.
    localparam logic [7:0] IDX_STAT = 8'h20;  // Link status.
    localparam logic [7:0] IDX_FWD = 8'hA0;   // Static forwarding.
    // Static registers serve links C,D,A,B,G,H,E,F: index xor 2.
    localparam logic [2:0] FWD_SWAP = 3'h2;
    // ============================================================
    // Configuration register fields.
    localparam int B_EN = 31;                 // Link enable.
    localparam int B_WIDE = 30;               // Five wire mode.
    localparam int B_ERR = 27;                // Receive error.
    localparam int B_ISSUED = 26;             // Credit issued.
    localparam int B_HELD = 25;               // Credit held.
    localparam int B_GREET = 24;              // Send greeting.
    localparam int B_RXRST = 23;              // Receiver reset.
    localparam int B_SGAP = 11;               // Symbol gap field.
    localparam int B_TGAP = 0;                // Token gap field.
    // Static forwarding fields.
    localparam int B_SEN = 31;                // Static enable.
    localparam int B_PROC = 8;                // Forward processor.
    localparam int B_CHAN = 0;                // Forward channel end.
    // Status fields.
    localparam int B_JUNK = 2;                // Packet is junk.
    localparam int B_DST = 1;                 // Destination side busy.
    localparam int B_SRC = 0;                 // Source side busy.
    // ============================================================
    // Control token codes.
    localparam logic [7:0] CT_CREDIT = 8'h01; // Grants one token.
    localparam logic [7:0] CT_GREET = 8'h02;  // Greeting token.
    // Transmit states, one-hot.
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SYM1 = 3'b010,
        TX_GAP = 3'b100
    } lcsf_tx_state_type;
endpackage

// [src/lcsf_stream_if.sv]
// Purpose: Valid/ready carrier between the block and its FIFO.
// Assumes: Both sides run on the same clock.
// Notes: The push side fills; the pop side drains.
`timescale 1ns/1ps
interface lcsf_stream_if #(parameter int W = 8);
    logic push_valid;      // Producer offers a word.
    logic push_ready;      // FIFO has room.
    logic [W-1:0] push_data; // Word offered.
    logic pop_valid;       // FIFO holds a word.
    logic pop_ready;       // Consumer takes the word.
    logic [W-1:0] pop_data; // Oldest word.
    // The FIFO end.
    modport fifo(input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data);
    // The user end.
    modport user(output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data);
endinterface

// [src/lcsf_top.sv]
// Purpose: Link configuration, credit, framing and static forwarding.
// Assumes: Inputs synchronous to mclk; remote end keeps the credit rules.
// Notes: Received tokens wait in a one-token buffer per link.
`timescale 1ns/1ps
module lcsf_top #(
    parameter int NL = lcsf_pkg::NLINK,
    parameter int FD = lcsf_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [NL-1:0] link_en,
    output logic [NL-1:0] link_wide,
    output logic [NL-1:0] link_tx_valid,
    output logic [NL-1:0][lcsf_pkg::SYM_W-1:0] link_tx_sym,
    input wire logic [NL-1:0] link_rx_valid,
    input wire logic [NL-1:0][lcsf_pkg::SYM_W-1:0] link_rx_sym,
    input wire logic [NL-1:0] tx_valid,
    input wire logic [NL-1:0][7:0] tx_data,
    output logic [NL-1:0] tx_ready,
    output logic fwd_valid,
    output logic [lcsf_pkg::LINK_W-1:0] fwd_link,
    output logic fwd_proc,
    output logic [lcsf_pkg::CHAN_W-1:0] fwd_chan,
    output logic [7:0] fwd_data,
    input wire logic fwd_ready,
    output logic rt_valid,
    output logic [lcsf_pkg::LINK_W-1:0] rt_link,
    output logic [7:0] rt_data
);
    localparam int LW = lcsf_pkg::LINK_W;
    localparam int GW = lcsf_pkg::GAP_W;
    localparam int CW = lcsf_pkg::CNT_W;
    localparam int SW = lcsf_pkg::SYM_W;
    localparam int HW = lcsf_pkg::CHAN_W;
    localparam int FW = lcsf_pkg::FWD_W;
    // ============================================================
    // Parameter check.
    if (NL != lcsf_pkg::NLINK || FD < 2) begin : g_bad_param
        $error("Link count must be eight and FIFO depth two or more.");
    end
    // ============================================================
    // State.
    typedef struct packed {
        logic [NL-1:0] en;          // Link enabled.
        logic [NL-1:0] wide;        // Five wire mode.
        logic [NL-1:0] err;         // Sticky receive error.
        logic [NL-1:0] issued;      // Credit granted to remote.
        logic [NL-1:0] held;        // Credit to transmit.
        logic [NL-1:0] greet_pend;  // Greeting waits to go.
        logic [NL-1:0] credit_pend; // Credit token waits to go.
        logic [NL-1:0] junk;        // Current token discarded.
        logic [NL-1:0] phase;       // Second symbol expected.
        logic [NL-1:0] rx_ctrl;     // First symbol control flag.
        logic [NL-1:0][3:0] rx_hi;  // First symbol payload.
        logic [NL-1:0] hold_v;      // Receive buffer full.
        logic [NL-1:0][7:0] hold_d; // Receive buffer word.
        lcsf_pkg::lcsf_tx_state_type [NL-1:0] tx_st; // Transmitter.
        logic [NL-1:0][CW-1:0] cnt; // Idle gap counter.
        logic [NL-1:0][8:0] tx_tok; // Token being sent.
        logic [NL-1:0] tx_rdy;      // Data accepted next cycle.
        logic [NL-1:0] sym_v;       // Symbol out strobe.
        logic [NL-1:0][SW-1:0] sym; // Symbol out.
        logic [NL-1:0][GW-1:0] sgap; // Symbol gap minus one.
        logic [NL-1:0][GW-1:0] tgap; // Token gap minus one.
        logic [NL-1:0] sen;         // Static forwarding on.
        logic [NL-1:0] sproc;       // Forward processor.
        logic [NL-1:0][HW-1:0] schan; // Forward channel end.
        logic [31:0] rdata;         // Read data.
        logic fv;                   // Forward output valid.
        logic [FW-1:0] fd;          // Forward output word.
        logic rv;                   // Routed token strobe.
        logic [LW-1:0] rl;          // Routed token link.
        logic [7:0] rd;             // Routed token data.
    } lcsf_state_type;
    lcsf_state_type q;
    lcsf_state_type d;
    // FIFO carrier and its drive.
    lcsf_stream_if #(.W(FW)) fq();
    logic push_v;
    logic [FW-1:0] push_d;
    logic pop_rdy;
    assign fq.push_valid = push_v;
    assign fq.push_data = push_d;
    assign fq.pop_ready = pop_rdy;
    // The output stage takes a word when it is empty or being drained.
    assign pop_rdy = !q.fv || fwd_ready;
    // ============================================================
    // Forward FIFO.
    lcsf_fifo #(.W(FW), .D(FD)) u_fifo (
        .clk(mclk),
        .rst(rst),
        .port(fq)
    );
    // ============================================================
    // Address helpers.
    // True when a word index falls in a bank of NL registers.
    function automatic logic in_bank(input logic [7:0] idx,
                                     input logic [7:0] base);
        logic [7:0] off;
        off = idx - base;
        return off < 8'(NL);
    endfunction
    // Register number within a bank.
    function automatic logic [LW-1:0] bank_sel(input logic [7:0] idx,
                                               input logic [7:0] base);
        logic [7:0] off;
        off = idx - base;
        return off[LW-1:0];
    endfunction
    // ============================================================
    // Next-state logic.
    always_comb begin
        logic [7:0] widx;
        logic [LW-1:0] k;
        logic [NL-1:0] greet_set;
        logic [8:0] tok;
        logic [7:0] code;
        logic take;
        logic pushed;
        logic routed;
        widx = reg_addr[9:2];
        k = '0;
        greet_set = '0;
        tok = '0;
        code = '0;
        take = 1'b0;
        pushed = 1'b0;
        routed = 1'b0;
        push_v = 1'b0;
        push_d = '0;
        d = q;
        d.rdata = '0;
        d.sym_v = '0;
        d.rv = 1'b0;
        // Register writes; pulse bits act and are not stored.
        if (reg_wr) begin
            if (in_bank(widx, lcsf_pkg::IDX_CFG)) begin
                k = bank_sel(widx, lcsf_pkg::IDX_CFG);
                d.en[k] = reg_wdata[lcsf_pkg::B_EN];
                d.wide[k] = reg_wdata[lcsf_pkg::B_WIDE];
                d.sgap[k] = reg_wdata[lcsf_pkg::B_SGAP+:GW];
                d.tgap[k] = reg_wdata[lcsf_pkg::B_TGAP+:GW];
                if (reg_wdata[lcsf_pkg::B_GREET]) begin
                    d.held[k] = 1'b0;
                    greet_set[k] = 1'b1;
                end
                if (reg_wdata[lcsf_pkg::B_RXRST]) begin
                    // Framing restarts; the error flag is cleared too.
                    d.phase[k] = 1'b0;
                    d.err[k] = 1'b0;
                    d.junk[k] = 1'b0;
                end
            end else if (in_bank(widx, lcsf_pkg::IDX_FWD)) begin
                k = bank_sel(widx, lcsf_pkg::IDX_FWD);
                k = k ^ lcsf_pkg::FWD_SWAP;
                d.sen[k] = reg_wdata[lcsf_pkg::B_SEN];
                d.sproc[k] = reg_wdata[lcsf_pkg::B_PROC];
                d.schan[k] = reg_wdata[lcsf_pkg::B_CHAN+:HW];
            end
        end
        // Register reads; unmapped words read as zero.
        if (reg_rd) begin
            if (in_bank(widx, lcsf_pkg::IDX_CFG)) begin
                k = bank_sel(widx, lcsf_pkg::IDX_CFG);
                d.rdata[lcsf_pkg::B_EN] = q.en[k];
                d.rdata[lcsf_pkg::B_WIDE] = q.wide[k];
                d.rdata[lcsf_pkg::B_ERR] = q.err[k];
                d.rdata[lcsf_pkg::B_ISSUED] = q.issued[k];
                d.rdata[lcsf_pkg::B_HELD] = q.held[k];
                d.rdata[lcsf_pkg::B_SGAP+:GW] = q.sgap[k];
                d.rdata[lcsf_pkg::B_TGAP+:GW] = q.tgap[k];
            end else if (in_bank(widx, lcsf_pkg::IDX_STAT)) begin
                k = bank_sel(widx, lcsf_pkg::IDX_STAT);
                d.rdata[lcsf_pkg::B_JUNK] = q.junk[k];
                d.rdata[lcsf_pkg::B_DST] = q.hold_v[k];
                d.rdata[lcsf_pkg::B_SRC] =
                    (q.tx_st[k] != lcsf_pkg::TX_IDLE);
            end else if (in_bank(widx, lcsf_pkg::IDX_FWD)) begin
                k = bank_sel(widx, lcsf_pkg::IDX_FWD);
                k = k ^ lcsf_pkg::FWD_SWAP;
                d.rdata[lcsf_pkg::B_SEN] = q.sen[k];
                d.rdata[lcsf_pkg::B_PROC] = q.sproc[k];
                d.rdata[lcsf_pkg::B_CHAN+:HW] = q.schan[k];
            end
        end
        // Drain receive buffers, lowest link first. A static link
        // waits for FIFO room; one FIFO push and one routed token
        // may leave per cycle.
        for (int i = 0; i < NL; i++) begin
            if (q.hold_v[i]) begin
                if (q.sen[i]) begin
                    if (!pushed && fq.push_ready) begin
                        pushed = 1'b1;
                        push_v = 1'b1;
                        push_d = {LW'(i), q.sproc[i], q.schan[i],
                                  q.hold_d[i]};
                        d.hold_v[i] = 1'b0;
                    end
                end else if (!routed) begin
                    routed = 1'b1;
                    d.rv = 1'b1;
                    d.rl = LW'(i);
                    d.rd = q.hold_d[i];
                    d.hold_v[i] = 1'b0;
                end
            end
        end
        // Per-link transmitter and receiver.
        for (int i = 0; i < NL; i++) begin
            if (!q.en[i]) begin
                // A disabled link aborts its token and ignores input.
                d.tx_st[i] = lcsf_pkg::TX_IDLE;
                d.cnt[i] = '0;
            end else begin
                case (q.tx_st[i])
                    lcsf_pkg::TX_IDLE: begin
                        // Control tokens go first, data needs credit.
                        take = 1'b1;
                        if (q.greet_pend[i]) begin
                            tok = {1'b1, lcsf_pkg::CT_GREET};
                            d.greet_pend[i] = 1'b0;
                        end else if (q.credit_pend[i]) begin
                            tok = {1'b1, lcsf_pkg::CT_CREDIT};
                            d.credit_pend[i] = 1'b0;
                        end else if (q.tx_rdy[i] && tx_valid[i]) begin
                            tok = {1'b0, tx_data[i]};
                            d.held[i] = 1'b0;
                        end else begin
                            take = 1'b0;
                        end
                        if (take) begin
                            d.sym_v[i] = 1'b1;
                            d.sym[i] = {tok[8], tok[7:4]};
                            d.tx_tok[i] = tok;
                            d.cnt[i] = {1'b0, q.sgap[i]} + 12'h001;
                            d.tx_st[i] = lcsf_pkg::TX_SYM1;
                        end
                    end
                    lcsf_pkg::TX_SYM1: begin
                        // Hold off the second symbol for the gap.
                        if (q.cnt[i] != '0) begin
                            d.cnt[i] = q.cnt[i] - 12'h001;
                        end else begin
                            d.sym_v[i] = 1'b1;
                            d.sym[i] = {1'b0, q.tx_tok[i][3:0]};
                            d.cnt[i] = {1'b0, q.tgap[i]} + 12'h001;
                            d.tx_st[i] = lcsf_pkg::TX_GAP;
                        end
                    end
                    lcsf_pkg::TX_GAP: begin
                        // Spacing between tokens.
                        if (q.cnt[i] <= 12'h001) begin
                            d.cnt[i] = '0;
                            d.tx_st[i] = lcsf_pkg::TX_IDLE;
                        end else begin
                            d.cnt[i] = q.cnt[i] - 12'h001;
                        end
                    end
                    default: begin
                        d.tx_st[i] = lcsf_pkg::TX_IDLE;
                    end
                endcase
                // Receive framing: two symbols make one token.
                if (link_rx_valid[i]) begin
                    if (!d.phase[i]) begin
                        d.phase[i] = 1'b1;
                        d.rx_ctrl[i] = link_rx_sym[i][4];
                        d.rx_hi[i] = link_rx_sym[i][3:0];
                        d.junk[i] = 1'b0;
                    end else begin
                        d.phase[i] = 1'b0;
                        code = {q.rx_hi[i], link_rx_sym[i][3:0]};
                        if (link_rx_sym[i][4]) begin
                            // A flag in the second symbol is illegal.
                            d.err[i] = 1'b1;
                            d.junk[i] = 1'b1;
                        end else if (q.rx_ctrl[i]) begin
                            if (code == lcsf_pkg::CT_CREDIT) begin
                                d.held[i] = 1'b1;
                            end else if (code == lcsf_pkg::CT_GREET) begin
                                // The far end dropped our grant.
                                d.issued[i] = 1'b0;
                            end else begin
                                d.err[i] = 1'b1;
                                d.junk[i] = 1'b1;
                            end
                        end else if (d.hold_v[i]) begin
                            // Data with a full buffer is an overflow.
                            d.err[i] = 1'b1;
                            d.junk[i] = 1'b1;
                        end else begin
                            d.hold_v[i] = 1'b1;
                            d.hold_d[i] = code;
                            d.issued[i] = 1'b0;
                        end
                    end
                end
                // Grant one token of credit once the buffer is free.
                if (!d.issued[i] && !d.hold_v[i] &&
                    !d.credit_pend[i]) begin
                    d.credit_pend[i] = 1'b1;
                    d.issued[i] = 1'b1;
                end
            end
            d.greet_pend[i] = d.greet_pend[i] | greet_set[i];
            // Ready only when idle with credit and nothing queued.
            d.tx_rdy[i] = d.en[i] && d.held[i] &&
                (d.tx_st[i] == lcsf_pkg::TX_IDLE) &&
                !d.greet_pend[i] && !d.credit_pend[i];
        end
        // Registered forward output stage.
        if (fq.pop_valid && pop_rdy) begin
            d.fv = 1'b1;
            d.fd = fq.pop_data;
        end else if (fwd_ready) begin
            d.fv = 1'b0;
        end
    end
    // ============================================================
    // State register; reset clears every field except tx_st, which loads TX_IDLE.
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
            for (int i = 0; i < NL; i++) begin
                q.tx_st[i] <= lcsf_pkg::TX_IDLE;
            end
        end else begin
            q <= d;
        end
    end
    // ============================================================
    // Outputs straight from the state register.
    assign reg_rdata = q.rdata;
    assign link_en = q.en;
    assign link_wide = q.wide;
    assign link_tx_valid = q.sym_v;
    assign link_tx_sym = q.sym;
    assign tx_ready = q.tx_rdy;
    assign fwd_valid = q.fv;
    assign fwd_link = q.fd[FW-1-:LW];
    assign fwd_proc = q.fd[HW+8];
    assign fwd_chan = q.fd[8+:HW];
    assign fwd_data = q.fd[7:0];
    assign rt_valid = q.rv;
    assign rt_link = q.rl;
    assign rt_data = q.rd;
endmodule

// [verification/lcsf_checker.sv]
// Purpose: Port assertions for the link configuration block.
// Assumes: Link 0 and the first configuration word are exercised.
// Notes: Bound to lcsf_top at the foot of this file.
`timescale 1ns/1ps
module lcsf_checker #(parameter int NL = 8) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [NL-1:0] link_en,
    input wire logic [NL-1:0] link_wide,
    input wire logic [NL-1:0] link_tx_valid,
    input wire logic [NL-1:0] tx_valid,
    input wire logic [NL-1:0] tx_ready,
    input wire logic fwd_valid,
    input wire logic [7:0] fwd_data,
    input wire logic fwd_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // A write to the configuration word of link 0.
    sequence cfg0_wr;
        reg_wr && reg_addr[9:2] == 8'h80;
    endsequence
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray data");
    chk_rd_unmapped: assert property (
        reg_rd && reg_addr[9:2] == 8'h00 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_en_write: assert property (
        cfg0_wr |=> link_en[0] == $past(reg_wdata[31]))
        else $error("enable not taken");
    chk_wide_write: assert property (
        cfg0_wr |=> link_wide[0] == $past(reg_wdata[30]))
        else $error("width not taken");
    chk_wide_hold: assert property (
        !(reg_wr && reg_addr[9:2] == 8'h80) |=> $stable(link_wide[0]))
        else $error("width changed alone");
    chk_tx_launch: assert property (
        tx_valid[0] && tx_ready[0] |=> link_tx_valid[0] && !tx_ready[0])
        else $error("token not launched");
    chk_sym_idle: assert property (
        link_tx_valid[0] |=> !link_tx_valid[0]) else $error("no idle gap");
    chk_fwd_hold: assert property (
        fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_data))
        else $error("forward word dropped");
endmodule
bind lcsf_top lcsf_checker #(.NL(NL)) lcsf_checker_i (.*);

// [verification/lcsf_remote.sv]
// Purpose: Remote link end facing link 0.
// Assumes: Tokens are two symbols, control flag in bit 4.
// Notes: Between symbols the line shows the inverse of the last one.
`timescale 1ns/1ps
module lcsf_remote (
    input wire logic mclk,
    input wire logic tx_v,
    input wire logic [4:0] tx_sym,
    output logic rx_v = 0,
    output logic [4:0] rx_sym = 5'h15
);
    int credit = 0; // Data tokens we may still send.
    logic [4:0] first = 0; // Last symbol seen; the first symbol of a token while half is set.
    logic half = 0; // A first symbol is pending.
    // Count credit tokens from the device.
    always @(posedge mclk) if (tx_v) begin
        if (half && first == 5'h10 && tx_sym == 5'h01) credit++;
        first = tx_sym;
        half = !half;
    end
    // Send one token; data waits for credit, slow stretches the gap.
    task automatic send(input logic [4:0] s0, s1, input int slow);
        for (int i = 0; i < 200 && !s0[4] && credit == 0; i++)
            @(posedge mclk);
        if (!s0[4]) credit--;
        @(posedge mclk) {rx_v, rx_sym} <= {1'b1, s0};
        @(posedge mclk) {rx_v, rx_sym} <= {1'b0, ~s0};
        repeat (slow) @(posedge mclk);
        @(posedge mclk) {rx_v, rx_sym} <= {1'b1, s1};
        @(posedge mclk) {rx_v, rx_sym} <= {1'b0, ~s1};
    endtask
endmodule

// [verification/testbench.sv]
// Purpose: Self-checking bench for the link configuration block.
// Assumes: Link 0 faces the remote model; other links stay quiet.
// Notes: Every wait is bounded to 100 cycles, except the credit wait in send, bounded to 200.
`timescale 1ns/1ps
module testbench;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, fwd_ready = 0, rv;
    logic [9:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, v;
    logic [7:0] link_en, link_wide, link_tx_valid, tx_valid = 0, tx_ready;
    logic [7:0][4:0] link_tx_sym;
    logic [7:0][7:0] tx_data = 0;
    logic [4:0] rs, fwd_chan;
    logic [7:0] fwd_data, rt_data;
    logic [2:0] fwd_link, rt_link;
    logic fwd_valid, fwd_proc, rt_valid;
    int failures = 0, compares = 0, n;
    always #4 mclk = ~mclk;
    lcsf_top lcsf_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_en(link_en), .link_wide(link_wide),
        .link_tx_valid(link_tx_valid), .link_tx_sym(link_tx_sym),
        .link_rx_valid({7'h0, rv}), .link_rx_sym({35'h0, rs}),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .fwd_valid(fwd_valid), .fwd_link(fwd_link), .fwd_proc(fwd_proc),
        .fwd_chan(fwd_chan), .fwd_data(fwd_data), .fwd_ready(fwd_ready),
        .rt_valid(rt_valid), .rt_link(rt_link), .rt_data(rt_data));
    lcsf_remote lcsf_remote_i (.mclk(mclk), .tx_v(link_tx_valid[0]),
        .tx_sym(link_tx_sym[0]), .rx_v(rv), .rx_sym(rs));
    task automatic give_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bound();
        if (n >= 100) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, idx, 2'h0, d};
        @(posedge mclk) reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] idx);
        @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, idx, 2'h0};
        @(posedge mclk) reg_rd <= 0;
        #1 v = reg_rdata;
    endtask
    task automatic t_link();
        wr(8'h80, 32'hC000_1805);
        repeat (12) @(posedge mclk);
        rd(8'h80); cmp(v, 32'hC400_1805);
        lcsf_remote_i.send(5'h10, 5'h01, 0);
        rd(8'h80); cmp(v, 32'hC600_1805);
        @(posedge mclk) {tx_valid[0], tx_data[0]} <= {1'b1, 8'hA5};
        for (n = 0; n < 100 && !link_tx_valid[0]; n++) @(posedge mclk) #1;
        bound();
        @(posedge mclk) tx_valid[0] <= 0;
        #1;
        for (n = 1; n < 100 && !link_tx_valid[0]; n++) @(posedge mclk) #1;
        bound();
        cmp(n, 5);
        rd(8'h80); cmp(v, 32'hC400_1805);
    endtask
    task automatic t_static();
        wr(8'hA2, 32'h8000_0113);
        lcsf_remote_i.send(5'h03, 5'h0C, 2);
        for (n = 0; n < 100 && !fwd_valid; n++) @(posedge mclk) #1;
        bound();
        repeat (3) @(posedge mclk);
        cmp({fwd_link, fwd_proc, fwd_chan, fwd_data}, 32'h333C);
        @(posedge mclk) fwd_ready <= 1;
        @(posedge mclk) fwd_ready <= 0;
    endtask
    task automatic t_errors();
        lcsf_remote_i.send(5'h13, 5'h00, 0);
        rd(8'h80); cmp(v & 32'h0800_0000, 32'h0800_0000);
        rd(8'h20); cmp(v & 32'h4, 32'h4);
        wr(8'h80, 32'hC080_1805);
        rd(8'h80); cmp(v & 32'h0880_0000, 32'h0);
        lcsf_remote_i.send(5'h10, 5'h01, 0);
        wr(8'h80, 32'hC100_1805);
        rd(8'h80); cmp(v & 32'h0300_0000, 32'h0);
    endtask
    task automatic t_route();
        wr(8'hA2, 32'h0);
        lcsf_remote_i.send(5'h05, 5'h0A, 0);
        for (n = 0; n < 100 && !rt_valid; n++) @(posedge mclk) #1;
        bound();
        cmp({rt_link, rt_data}, 32'h5A);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 0;
        rd(8'h80); cmp(v, 32'h0);
        rd(8'hA0); cmp(v, 32'h0);
        rd(8'h00); cmp(v, 32'h0);
        t_link();
        t_static();
        t_errors();
        t_route();
        give_verdict();
    end
endmodule
